/* File: bench/rtc_alarm_control_flags_test.sv */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module rtc_alarm_control_flags_test;
    import rac_pkg::*;
    localparam int OPT = 2;
    // Osc tick every 4 cycles, so one 256 Hz tick is OPT * 4 cycles
    localparam int TCYC = OPT * 4;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic manual_rst_i = 1'b0;
    logic standby_i = 1'b0;
    rac_bus_req_s bus = '0;
    logic [7:0] rdata_o;
    logic osc_tick = 1'b0;
    logic tick_en = 1'b1;
    logic [1:0] div = 2'h0;
    logic [7:0] mon_cnt = 8'h01;
    logic [7:0] sec_cnt = 8'h00;
    logic cnt_read = 1'b0;
    logic [4:0] oth_en = 5'h00;
    logic [4:0] oth_eq = 5'h00;
    logic osc_run_o, count_run_o, sec_tick_o, sec_clear_o, min_advance_o;
    logic carry_irq_o, alarm_irq_o, periodic_irq_o;
    logic [7:0] d;
    logic [7:0] d2;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_sec = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i) begin
        if (sec_tick_o === 1'b1) begin
            n_sec <= n_sec + 1;
        end
    end

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        div <= div + 2'h1;
        osc_tick <= tick_en && (div == 2'h0);
    end

    rac_ctl #(.OSC_PER_TICK(OPT)) dut_u (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .manual_rst_i(manual_rst_i),
        .standby_i(standby_i), .bus_i(bus), .rdata_o(rdata_o), .osc_tick_i(osc_tick),
        .month_counter_i(mon_cnt), .seconds_counter_i(sec_cnt), .cnt_read_i(cnt_read),
        .other_alarm_en_i(oth_en), .other_alarm_eq_i(oth_eq), .osc_run_o(osc_run_o),
        .count_run_o(count_run_o), .sec_tick_o(sec_tick_o), .sec_clear_o(sec_clear_o),
        .min_advance_o(min_advance_o), .carry_irq_o(carry_irq_o),
        .alarm_irq_o(alarm_irq_o), .periodic_irq_o(periodic_irq_o)
    );

    task automatic finish_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic pass_cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys_i);
        bus.addr <= a;
        bus.wdata <= v;
        bus.wr <= 1'b1;
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        rd(a, d);
        `CHK("rdata", e, d)
    endtask

    // Bounded wait; the flag is a level, so sampling just after the edge is safe
    task automatic wait_per(input int lim);
        int i;
        for (i = 0; i < lim && periodic_irq_o !== 1'b1; i++) begin
            pass_cyc(1);
        end
        if (i == lim) begin
            num_errors++;
            finish_test();
        end
    endtask

    task automatic t_reset();
        `CHK("osc_run", 1'b1, osc_run_o)
        `CHK("count_run", 1'b1, count_run_o)
        rchk(OFF_MON_ALARM, 8'h00);
        rchk(OFF_CTL1, CTL1_RST);
        rchk(OFF_CTL2, CTL2_RST);
        rchk(4'h2, 8'h00);
    endtask

    task automatic t_alarm();
        wr(OFF_CTL2, 8'h08);
        @(posedge clk_sys_i);
        oth_en <= 5'h01;
        mon_cnt <= 8'h12;
        wr(OFF_CTL1, 8'h08);
        wr(OFF_MON_ALARM, 8'hF2);
        rchk(OFF_MON_ALARM, 8'h92);
        `CHK("alarm_irq", 1'b0, alarm_irq_o)
        @(posedge clk_sys_i);
        oth_eq <= 5'h01;
        pass_cyc(3);
        `CHK("alarm_irq", 1'b1, alarm_irq_o)
        wr(OFF_CTL1, 8'h09);
        rchk(OFF_CTL1, 8'h09);
        wr(OFF_CTL1, 8'h08);
        pass_cyc(1);
        `CHK("alarm_irq", 1'b0, alarm_irq_o)
        wr(OFF_CTL1, 8'h00);
        @(posedge clk_sys_i);
        oth_eq <= 5'h00;
        pass_cyc(2);
        oth_eq <= 5'h01;
        pass_cyc(3);
        rchk(OFF_CTL1, 8'h01);
        `CHK("alarm_irq", 1'b0, alarm_irq_o)
        wr(OFF_CTL1, 8'h00);
        wr(OFF_CTL2, 8'h09);
    endtask

    task automatic t_carry();
        wr(OFF_CTL1, 8'h90);
        pass_cyc(2);
        `CHK("carry_irq", 1'b1, carry_irq_o)
        rchk(OFF_CTL1, 8'h90);
        wr(OFF_CTL1, 8'h00);
        rchk(OFF_CTL1, 8'h00);
        `CHK("carry_irq", 1'b0, carry_irq_o)
        @(posedge clk_sys_i);
        cnt_read <= 1'b1;
        pass_cyc(2 * TCYC);
        @(posedge clk_sys_i);
        cnt_read <= 1'b0;
        rchk(OFF_CTL1, 8'h80);
        `CHK("carry_irq", 1'b0, carry_irq_o)
        wr(OFF_CTL1, 8'h66);
        rchk(OFF_CTL1, 8'h00);
    endtask

    task automatic t_period();
        int tk[8] = '{0, 1, 4, 16, 64, 128, 256, 512};
        int t0;
        int n0;
        for (int s = 1; s < 8; s++) begin
            wr(OFF_CTL2, {1'b0, 3'(s), 4'h9});
            wait_per(600 * TCYC);
            t0 = cyc;
            n0 = n_sec;
            wr(OFF_CTL2, {1'b0, 3'(s), 4'h9});
            pass_cyc(1);
            wait_per(600 * TCYC);
            `CHK("period", tk[s] * TCYC, cyc - t0)
            if (s >= 6) `CHK("sec_tick", tk[s] / 256, n_sec - n0)
        end
        wr(OFF_CTL2, 8'h09);
    endtask

    task automatic t_adjust();
        @(posedge clk_sys_i);
        sec_cnt <= 8'h29;
        wr(OFF_CTL2, 8'h0D);
        `CHK("sec_clear", 1'b1, sec_clear_o)
        `CHK("min_adv", 1'b0, min_advance_o)
        rchk(OFF_CTL2, 8'h09);
        @(posedge clk_sys_i);
        sec_cnt <= 8'h30;
        wr(OFF_CTL2, 8'h0D);
        `CHK("min_adv", 1'b1, min_advance_o)
    endtask

    task automatic t_div();
        wr(OFF_CTL2, 8'h08);
        `CHK("count_run", 1'b0, count_run_o)
        rd(OFF_HZ64, d2);
        pass_cyc(8 * TCYC);
        rd(OFF_HZ64, d);
        `CHK("hz64_runs", 1'b1, d !== d2)
        wr(OFF_CTL2, 8'h00);
        `CHK("osc_run", 1'b0, osc_run_o)
        rd(OFF_HZ64, d2);
        pass_cyc(8 * TCYC);
        rchk(OFF_HZ64, d2);
        @(posedge clk_sys_i);
        tick_en <= 1'b0;
        wr(OFF_CTL2, 8'h0A);
        rchk(OFF_HZ64, 8'h00);
        rchk(OFF_CTL2, 8'h08);
        @(posedge clk_sys_i);
        tick_en <= 1'b1;
        wr(OFF_CTL2, 8'h09);
    endtask

    // Standby, manual reset and a second power-on reset in mid-run
    task automatic t_resets();
        wr(OFF_CTL2, 8'h08);
        @(posedge clk_sys_i);
        mon_cnt <= 8'h01;
        wr(OFF_MON_ALARM, 8'h92);
        wr(OFF_CTL1, 8'h98);
        wr(OFF_CTL2, 8'h70);
        @(posedge clk_sys_i);
        standby_i <= 1'b1;
        wr(OFF_CTL1, 8'h00);
        @(posedge clk_sys_i);
        standby_i <= 1'b0;
        rchk(OFF_CTL1, 8'h98);
        @(posedge clk_sys_i);
        manual_rst_i <= 1'b1;
        @(posedge clk_sys_i);
        manual_rst_i <= 1'b0;
        rchk(OFF_CTL1, 8'h80);
        rchk(OFF_CTL2, 8'h00);
        rchk(OFF_MON_ALARM, 8'h92);
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        rchk(OFF_MON_ALARM, 8'h00);
        rchk(OFF_CTL2, CTL2_RST);
    endtask

    initial begin
        repeat (6) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_alarm();
        t_carry();
        t_period();
        t_adjust();
        t_div();
        t_resets();
        finish_test();
    end
endmodule // rtc_alarm_control_flags_test

/* File: pkg/rac_pkg.sv */
package rac_pkg;

    // Register byte addresses
    localparam logic [3:0] OFF_MON_ALARM = 4'h0;
    localparam logic [3:0] OFF_CTL1 = 4'h4;
    localparam logic [3:0] OFF_CTL2 = 4'h8;
    localparam logic [3:0] OFF_HZ64 = 4'hC;

    // Field positions
    localparam int MON_ENB_BIT = 7;
    localparam int CTL1_CARRY_BIT = 7;
    localparam int CTL1_CIE_BIT = 4;
    localparam int CTL1_AIE_BIT = 3;
    localparam int CTL1_AF_BIT = 0;
    localparam int CTL2_PEF_BIT = 7;
    localparam int CTL2_PES_LSB = 4;
    localparam int CTL2_OSC_BIT = 3;
    localparam int CTL2_ADJ_BIT = 2;
    localparam int CTL2_DIVRST_BIT = 1;
    localparam int CTL2_START_BIT = 0;

    // Reset values and masks
    localparam logic [7:0] CTL1_RST = 8'h00;
    localparam logic [7:0] CTL2_RST = 8'h09;
    localparam logic [7:0] MON_RD_MASK = 8'h9F;
    localparam logic [7:0] SEC_ROUND_THRESH = 8'h30;

    // Timing
    localparam int OSC_HZ = 32768;
    localparam int TICK_HZ = 256;
    localparam int DIV_BITS = 9;
    localparam int CLK_NS = 40;
    localparam int ADJ_MAX_NS = 91600;
    localparam int ADJ_MAX_CYC = ADJ_MAX_NS / CLK_NS;

    typedef enum logic [2:0] {
        PER_OFF = 3'b000,
        PER_256TH = 3'b001,
        PER_64TH = 3'b010,
        PER_16TH = 3'b011,
        PER_QUARTER = 3'b100,
        PER_HALF = 3'b101,
        PER_ONE = 3'b110,
        PER_TWO = 3'b111
    } rac_period_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rac_bus_req_s;

endpackage

/* File: rtl/rac_ctl.sv */
`timescale 1ns/100ps
// Summary of operation
// - Month alarm compare enable bit 7 compares alarm month against month counter.
// - Alarm matches only when all enabled alarm registers equal their counters.
// - Power-on clears month compare enable; month fields survive manual reset, standby.
// - Control one resets to zero; manual reset leaves carry flag; standby keeps.
// - Carry flag sets when a counter read meets a seconds or 64 Hz carry.
// - Writing 0 clears the carry flag, writing 1 sets it.
// - Carry interrupt requested while carry flag and carry enable bit 4 are set.
// - Alarm interrupt requested while alarm flag and alarm enable bit 3 are set.
// - Alarm flag sets on match; write 0 clears, write 1 leaves it.
// - Reserved control one bits 6, 5, 2, 1 read zero; software writes zero.
// - Control two resets to 0x09; manual reset keeps run bits; standby keeps.
// - Periodic flag sets on interval, requests interrupt while set; write 0 clears.
// - Periodic select: off, 1/256, 1/64, 1/16, 1/4, 1/2, 1, 2 s.
// - Oscillator run bit 3 halts oscillator at 0, runs at 1 by reset.
// - Adjust rounds seconds 29 or less to 00, else next minute.
// - Adjust also resets divider chain and 64 Hz counter; reads zero.
// - Rounded seconds visible within about 91.6 us of the adjust write.
// - Divider reset write clears prescaler and 64 Hz counter; reads zero.
// - Count start bit 0 halts second to year counters at 0, counts at 1.
// - 64 Hz counter runs regardless of start, stops only with oscillator.
module rac_ctl
    import rac_pkg::*;
#(
    parameter int OSC_PER_TICK = OSC_HZ / TICK_HZ
) (
    // Clock and resets
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic manual_rst_i,
    input wire logic standby_i,
    // Register port
    input wire rac_bus_req_s bus_i,
    output logic [7:0] rdata_o,
    // Oscillator and counter side
    input wire logic osc_tick_i,
    input wire logic [7:0] month_counter_i,
    input wire logic [7:0] seconds_counter_i,
    input wire logic cnt_read_i,
    input wire logic [4:0] other_alarm_en_i,
    input wire logic [4:0] other_alarm_eq_i,
    output logic osc_run_o,
    output logic count_run_o,
    output logic sec_tick_o,
    output logic sec_clear_o,
    output logic min_advance_o,
    // Interrupt requests
    output logic carry_irq_o,
    output logic alarm_irq_o,
    output logic periodic_irq_o
);

    // Below two steps the prescaler would have no bits left to count with
    if (OSC_PER_TICK < 2 || OSC_PER_TICK > 4096) begin : gen_bad_div
        $error("OSC_PER_TICK out of range");
    end

    localparam int PRE_W = $clog2(OSC_PER_TICK);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(OSC_PER_TICK - 1);

    function automatic logic [DIV_BITS-1:0] period_mask(input logic [2:0] sel);
        logic [DIV_BITS-1:0] m;
        m = '0;
        case (rac_period_e'(sel))
            PER_256TH: m = 9'h000;
            PER_64TH: m = 9'h003;
            PER_16TH: m = 9'h00F;
            PER_QUARTER: m = 9'h03F;
            PER_HALF: m = 9'h07F;
            PER_ONE: m = 9'h0FF;
            PER_TWO: m = 9'h1FF;
            default: m = 9'h000;
        endcase
        return m;
    endfunction

    logic [7:0] mon_alarm_ff;
    logic [7:0] ctl1_ff;
    logic [7:0] ctl2_ff;
    logic [PRE_W-1:0] pre_ff;
    logic [DIV_BITS-1:0] div_ff;
    logic match_prev_ff;
    logic [7:0] rdata_ff;
    logic sec_clear_ff;
    logic min_adv_ff;

    logic wr_mon, wr_ctl1, wr_ctl2;
    logic osc_on, tick256, carry64, carry_sec, div_clear;
    logic all_match, match_rise, period_hit;
    logic [7:0] nxt_ctl1, nxt_ctl2;

    // Standby freezes every register write; contents are retained
    assign wr_mon = bus_i.wr && !standby_i && bus_i.addr == OFF_MON_ALARM;
    assign wr_ctl1 = bus_i.wr && !standby_i && bus_i.addr == OFF_CTL1;
    assign wr_ctl2 = bus_i.wr && !standby_i && bus_i.addr == OFF_CTL2;

    // Oscillator gate and divider chain
    assign osc_on = ctl2_ff[CTL2_OSC_BIT];
    assign osc_run_o = osc_on;
    assign count_run_o = ctl2_ff[CTL2_START_BIT];
    assign div_clear = wr_ctl2 && (bus_i.wdata[CTL2_ADJ_BIT] || bus_i.wdata[CTL2_DIVRST_BIT]);
    assign carry64 = osc_on && osc_tick_i && pre_ff == PRE_LAST;
    assign tick256 = carry64 && !div_clear;
    assign carry_sec = carry64 && div_ff[7:0] == 8'hFF;
    assign sec_tick_o = carry_sec && count_run_o && !div_clear;

    // Prescaler ignores the start bit; only the oscillator bit stops it
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_ff <= '0;
        end else if (div_clear) begin
            pre_ff <= '0;
        end else if (osc_on && osc_tick_i) begin
            pre_ff <= (pre_ff == PRE_LAST) ? '0 : pre_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_ff <= '0;
        end else if (div_clear) begin
            div_ff <= '0;
        end else if (tick256) begin
            div_ff <= div_ff + 1'b1;
        end
    end

    // Alarm match across all enabled registers
    assign all_match = (mon_alarm_ff[MON_ENB_BIT] || other_alarm_en_i != 5'h00)
        && (!mon_alarm_ff[MON_ENB_BIT] || mon_alarm_ff[4:0] == month_counter_i[4:0])
        && ((~other_alarm_en_i | other_alarm_eq_i) == 5'h1F);
    // Edge so that a cleared flag is not re-armed for the rest of the match
    assign match_rise = all_match && !match_prev_ff;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_prev_ff <= 1'b0;
        end else begin
            match_prev_ff <= all_match;
        end
    end

    // Month alarm; power-on clears the whole register, enable included
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mon_alarm_ff <= 8'h00;
        end else if (wr_mon) begin
            mon_alarm_ff <= bus_i.wdata & MON_RD_MASK;
        end
    end

    // Control one: hardware sets win over software clears
    always_comb begin
        nxt_ctl1 = ctl1_ff;
        if (wr_ctl1) begin
            nxt_ctl1[CTL1_CARRY_BIT] = bus_i.wdata[CTL1_CARRY_BIT];
            nxt_ctl1[CTL1_CIE_BIT] = bus_i.wdata[CTL1_CIE_BIT];
            nxt_ctl1[CTL1_AIE_BIT] = bus_i.wdata[CTL1_AIE_BIT];
            nxt_ctl1[CTL1_AF_BIT] = ctl1_ff[CTL1_AF_BIT] && bus_i.wdata[CTL1_AF_BIT];
        end
        if (cnt_read_i && (carry64 || carry_sec)) begin
            nxt_ctl1[CTL1_CARRY_BIT] = 1'b1;
        end
        if (match_rise) begin
            nxt_ctl1[CTL1_AF_BIT] = 1'b1;
        end
        nxt_ctl1[6:5] = 2'b00;
        nxt_ctl1[2:1] = 2'b00;
        if (manual_rst_i) begin
            nxt_ctl1 = {ctl1_ff[CTL1_CARRY_BIT], 7'h00};
        end else if (standby_i) begin
            nxt_ctl1 = ctl1_ff;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl1_ff <= CTL1_RST;
        end else begin
            ctl1_ff <= nxt_ctl1;
        end
    end

    // Control two; adjust and divider reset are strobes and never stored
    assign period_hit = tick256 && ctl2_ff[6:4] != PER_OFF
        && (div_ff & period_mask(ctl2_ff[6:4])) == period_mask(ctl2_ff[6:4]);

    always_comb begin
        nxt_ctl2 = ctl2_ff;
        if (wr_ctl2) begin
            nxt_ctl2 = bus_i.wdata;
            nxt_ctl2[CTL2_PEF_BIT] = bus_i.wdata[CTL2_PEF_BIT];
        end
        if (period_hit) begin
            nxt_ctl2[CTL2_PEF_BIT] = 1'b1;
        end
        nxt_ctl2[CTL2_ADJ_BIT] = 1'b0;
        nxt_ctl2[CTL2_DIVRST_BIT] = 1'b0;
        if (manual_rst_i) begin
            nxt_ctl2 = (CTL2_RST & 8'hF6) | (ctl2_ff & 8'h09);
        end else if (standby_i) begin
            nxt_ctl2 = ctl2_ff;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl2_ff <= CTL2_RST;
        end else begin
            ctl2_ff <= nxt_ctl2;
        end
    end

    // Half-minute rounding pulses to the seconds and minute counters
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sec_clear_ff <= 1'b0;
            min_adv_ff <= 1'b0;
        end else begin
            sec_clear_ff <= wr_ctl2 && bus_i.wdata[CTL2_ADJ_BIT];
            min_adv_ff <= wr_ctl2 && bus_i.wdata[CTL2_ADJ_BIT]
                && seconds_counter_i >= SEC_ROUND_THRESH;
        end
    end
    assign sec_clear_o = sec_clear_ff;
    assign min_advance_o = min_adv_ff;

    // Interrupt levels
    assign carry_irq_o = ctl1_ff[CTL1_CARRY_BIT] && ctl1_ff[CTL1_CIE_BIT];
    assign alarm_irq_o = ctl1_ff[CTL1_AF_BIT] && ctl1_ff[CTL1_AIE_BIT];
    assign periodic_irq_o = ctl2_ff[CTL2_PEF_BIT];

    // Read port, data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_ff <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                OFF_MON_ALARM: rdata_ff <= mon_alarm_ff & MON_RD_MASK;
                OFF_CTL1: rdata_ff <= ctl1_ff;
                OFF_CTL2: rdata_ff <= ctl2_ff;
                OFF_HZ64: rdata_ff <= {1'b0, div_ff[7:1]};
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end
    assign rdata_o = rdata_ff;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);

    reserved_zero_a: assert property (ctl1_ff[6:5] == 2'b00 && ctl1_ff[2:1] == 2'b00)
        else $error("reserved control one bits set");
    carry_set_a: assert property (cnt_read_i && carry64 && !manual_rst_i && !standby_i
        |=> ctl1_ff[CTL1_CARRY_BIT])
        else $error("carry flag missed a carry during read");
    carry_irq_a: assert property (carry_irq_o == (ctl1_ff[7] && ctl1_ff[4]))
        else $error("carry request wrong");
    af_write_one_a: assert property (wr_ctl1 && bus_i.wdata[0] && !manual_rst_i
        && !match_rise |=> ctl1_ff[0] == $past(ctl1_ff[0]))
        else $error("alarm flag changed on write of one");
    alarm_irq_a: assert property (ctl1_ff[0] && ctl1_ff[3] |-> alarm_irq_o)
        else $error("alarm request missing");
    strobe_zero_a: assert property (wr_ctl2 |=> ctl2_ff[2:1] == 2'b00)
        else $error("adjust or divider reset stored");
    div_clear_a: assert property (div_clear |=> pre_ff == '0 && div_ff == '0)
        else $error("divider not cleared");
    osc_stop_a: assert property (!osc_on && !div_clear |=> $stable(pre_ff))
        else $error("prescaler ran with oscillator off");
    manual_keep_a: assert property (manual_rst_i |=> ctl2_ff[3] == $past(ctl2_ff[3])
        && ctl2_ff[0] == $past(ctl2_ff[0]) && ctl2_ff[6:4] == 3'b000)
        else $error("manual reset mishandled control two");
    adjust_a: assert property (wr_ctl2 && bus_i.wdata[2] |=> sec_clear_o)
        else $error("rounding not issued in time");
    periodic_a: assert property (period_hit && !manual_rst_i && !standby_i
        |=> periodic_irq_o)
        else $error("periodic flag not set");

endmodule // rac_ctl
